//--- hw/gds_device.sv
// gds_device: serial slave and command registers of the gauge driver
//
// Implementation choice: the serial link slave port.
`timescale 1ns/100ps
`default_nettype none
module gds_device (
	// system
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// link
	gds_link_if.dev          link,
	// status word to report
	input  wire logic [15:0] statusWord,
	// command registers
	output logic      [12:0] powerEnableCalibration,
	output logic      [12:0] maximumVelocity,
	output logic      [12:0] gauge0TargetPosition,
	output logic      [12:0] gauge1TargetPosition,
	output logic      [12:0] returnToZeroCommand,
	output logic      [12:0] returnToZeroSetup,
	output logic             wordCommitted
);
	// ******************************
	// pin synchronisers
	// ******************************
	logic [1:0] csSync_r, sclkSync_r, mosiSync_r;
	logic       csPrev_r, sclkPrev_r, mosiPrev_r;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			csSync_r   <= 2'h3;
			sclkSync_r <= 2'h0;
			mosiSync_r <= 2'h0;
			csPrev_r   <= 1'b1;
			sclkPrev_r <= 1'b0;
			mosiPrev_r <= 1'b0;
		end else begin
			csSync_r   <= {csSync_r[0], link.csN};
			sclkSync_r <= {sclkSync_r[0], link.sclk};
			mosiSync_r <= {mosiSync_r[0], link.mosi};
			csPrev_r   <= csSync_r[1];
			sclkPrev_r <= sclkSync_r[1];
			// the master may move data with the falling edge itself, so
			// the bit is taken as it stood while the clock was still high
			mosiPrev_r <= mosiSync_r[1];
		end
	end
	wire csLow   = ~csSync_r[1];
	wire csRise  = csSync_r[1] & ~csPrev_r;
	wire sclkRise = csLow & sclkSync_r[1] & ~sclkPrev_r;
	wire sclkFall = csLow & ~sclkSync_r[1] & sclkPrev_r;

	// ******************************
	// shift registers
	// ******************************
	logic [15:0] rxShift_r, txShift_r;
	logic [3:0]  bitCnt_r;
	logic        anyBits_r, firstRise_r;
	logic        miso_r;
	// output shift holds status then received bits: the received stream is
	// fed into its bottom, so it leaves 16 bits late in arrival order
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxShift_r   <= 16'h0000;
			txShift_r   <= 16'h0000;
			bitCnt_r    <= 4'h0;
			anyBits_r   <= 1'b0;
			firstRise_r <= 1'b1;
			miso_r      <= 1'b0;
		end else if (!csLow) begin
			bitCnt_r    <= 4'h0;
			anyBits_r   <= 1'b0;
			firstRise_r <= 1'b1;
		end else begin
			if (sclkFall) begin
				rxShift_r <= {rxShift_r[14:0], mosiPrev_r};
				txShift_r <= {txShift_r[15:1], mosiPrev_r};
				bitCnt_r  <= bitCnt_r + 4'h1;
				anyBits_r <= 1'b1;
			end
			if (sclkRise) begin
				if (firstRise_r) begin
					miso_r      <= statusWord[15];
					txShift_r   <= {statusWord[14:0], 1'b0};
					firstRise_r <= 1'b0;
				end else begin
					miso_r    <= txShift_r[15];
					txShift_r <= {txShift_r[14:0], txShift_r[0]};
				end
			end
		end
	end
	assign link.miso   = miso_r;
	assign link.misoOe = csLow;

	// ******************************
	// commit on chip select rise
	// ******************************
	wire [2:0] rxAddr = rxShift_r[gds_pkg::ADDR_MSB:gds_pkg::ADDR_LSB];
	wire       wordOk = anyBits_r & (bitCnt_r == gds_pkg::BITCNT_ZERO);
	wire       doCommit = csRise & wordOk;
	wire [12:0] rxData = rxShift_r[12:0];
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			powerEnableCalibration <= gds_pkg::REG_RESET;
			maximumVelocity        <= gds_pkg::REG_RESET;
			gauge0TargetPosition   <= gds_pkg::REG_RESET;
			gauge1TargetPosition   <= gds_pkg::REG_RESET;
			returnToZeroCommand    <= gds_pkg::REG_RESET;
			returnToZeroSetup      <= gds_pkg::REG_RESET;
			wordCommitted          <= 1'b0;
		end else begin
			wordCommitted <= doCommit;
			if (doCommit) begin
				unique case (rxAddr)
				gds_pkg::ADDR_PEC:   powerEnableCalibration <= rxData;
				gds_pkg::ADDR_VEL:   maximumVelocity        <= rxData;
				gds_pkg::ADDR_POS0:  gauge0TargetPosition   <= rxData;
				gds_pkg::ADDR_POS1:  gauge1TargetPosition   <= rxData;
				gds_pkg::ADDR_RTZ:   returnToZeroCommand    <= rxData;
				gds_pkg::ADDR_RTZS:  returnToZeroSetup      <= rxData;
				gds_pkg::ADDR_UNUSED, gds_pkg::ADDR_TEST: ;
				endcase
			end
		end
	end
endmodule // gds_device
`default_nettype wire

//--- hw/gds_pkg.sv
// gds_pkg: constants shared by both ends of the gauge driver serial link
package gds_pkg;
	localparam int WORD_BITS = 16;
	localparam int ADDR_BITS = 3;
	localparam int DATA_BITS = 13;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 13;
	localparam logic [2:0] ADDR_PEC = 3'h0;
	localparam logic [2:0] ADDR_VEL = 3'h1;
	localparam logic [2:0] ADDR_POS0 = 3'h2;
	localparam logic [2:0] ADDR_POS1 = 3'h3;
	localparam logic [2:0] ADDR_RTZ = 3'h4;
	localparam logic [2:0] ADDR_RTZS = 3'h5;
	localparam logic [2:0] ADDR_UNUSED = 3'h6;
	localparam logic [2:0] ADDR_TEST = 3'h7;
	localparam logic [12:0] REG_RESET = 13'h0000;
	localparam logic [3:0] BITCNT_ZERO = 4'h0;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	// controller register map, byte addresses on APB
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TXDATA = 8'h04;
	localparam logic [7:0] OFS_RXDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam int CTRL_START = 0;
	localparam int STAT_BUSY = 0;
	// serial clock half period in system clocks (10 ns each)
	localparam int SCK_HALF_NS = 500;
	localparam int CLK_NS = 10;
	localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_NS;
	// chip select idle time between words, least
	localparam int CS_IDLE_NS = 5000;
	localparam int CS_IDLE_CYC = (CS_IDLE_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- hw/gds_link_if.sv
// gds_link_if: serial link between controller and gauge driver device
`timescale 1ns/100ps
`default_nettype none
interface gds_link_if;
	logic csN;
	logic sclk;
	logic mosi;
	logic miso;
	logic misoOe;
	modport ctrl (output csN, output sclk, output mosi, input miso);
	modport dev (input csN, input sclk, input mosi, output miso,
		output misoOe);
endinterface
`default_nettype wire

//--- hw/gds_controller.sv
// gds_controller: APB driven serial master for the gauge driver link
`timescale 1ns/100ps
`default_nettype none
module gds_controller (
	// system
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	gds_link_if.ctrl         link
);
	typedef enum logic [1:0] {IDLE, LOW, HIGH, GAP} gds_st_e;
	gds_st_e st_r;
	logic [15:0] tx_r, rx_r;
	logic [4:0]  bits_r;
	logic [9:0]  cnt_r;
	logic        cs_r, sck_r;
	logic [1:0]  misoSync_r;

	// ******************************
	// apb decode
	// ******************************
	wire acc     = psel & penable;
	wire busy    = (st_r != IDLE);
	wire wrTx    = acc & pwrite & (paddr == gds_pkg::OFS_TXDATA) & ~busy;
	wire wrStart = acc & pwrite & (paddr == gds_pkg::OFS_CTRL)
		& pwdata[gds_pkg::CTRL_START] & ~busy;
	wire known   = (paddr == gds_pkg::OFS_CTRL) | (paddr == gds_pkg::OFS_TXDATA)
		| (paddr == gds_pkg::OFS_RXDATA) | (paddr == gds_pkg::OFS_STATUS);
	assign pready  = 1'b1;
	assign pslverr = acc & ~known;
	always_comb begin
		prdata = 32'h00000000;
		if (paddr == gds_pkg::OFS_TXDATA)
			prdata = {16'h0000, tx_r};
		else if (paddr == gds_pkg::OFS_RXDATA)
			prdata = {16'h0000, rx_r};
		else if (paddr == gds_pkg::OFS_STATUS)
			prdata = {31'h00000000, busy};
	end

	// ******************************
	// serial master
	// ******************************
	wire tick = (cnt_r == 10'(gds_pkg::SCK_HALF_CYC - 1));
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= IDLE;
			tx_r <= 16'h0000;
			rx_r <= 16'h0000;
			bits_r <= 5'h00;
			cnt_r <= 10'h000;
			cs_r <= 1'b1;
			sck_r <= 1'b0;
			misoSync_r <= 2'h0;
		end else begin
			misoSync_r <= {misoSync_r[0], link.miso};
			cnt_r <= (tick || st_r == IDLE) ? 10'h000 : cnt_r + 10'h001;
			if (wrTx)
				tx_r <= pwdata[15:0];
			unique case (st_r)
			IDLE: if (wrStart) begin
				cs_r <= 1'b0; // clock is low here
				bits_r <= 5'h00;
				st_r <= LOW;
			end
			LOW: if (tick) begin
				if (bits_r == 5'h10) begin
					cs_r <= 1'b1;
					st_r <= GAP;
				end else begin
					sck_r <= 1'b1;
					rx_r <= {rx_r[14:0], misoSync_r[1]};
					st_r <= HIGH;
				end
			end
			HIGH: if (tick) begin
				// device samples on this falling edge, data set long ago
				sck_r <= 1'b0;
				tx_r <= {tx_r[14:0], 1'b0};
				bits_r <= bits_r + 5'h01;
				st_r <= LOW;
			end
			GAP: if (cnt_r == 10'h000 && bits_r == 5'h00)
				st_r <= IDLE;
			else if (tick)
				bits_r <= (bits_r == 5'h10) ? 5'h0A : bits_r - 5'h01;
			endcase
		end
	end
	assign link.csN  = cs_r;
	assign link.sclk = sck_r;
	assign link.mosi = tx_r[15];
endmodule // gds_controller
`default_nettype wire

//--- bench/gds_properties.sv
// gds_properties: link protocol checks
`timescale 1ns/100ps
`default_nettype none
module gds_properties (
	// system and link
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic misoOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [4:0] rise_r;
	logic [9:0] high_r;
	// cycles with select high since it last rose, saturating
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			high_r <= 10'h3FF;
		else if (!csN)
			high_r <= 10'h000;
		else if (high_r != 10'h3FF)
			high_r <= high_r + 10'h001;
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			rise_r <= 5'h00;
		else
			rise_r <= csN ? 5'h00 : rise_r + 5'($rose(sclk));
	property p_idle; csN[*4] |-> !misoOe; endproperty
	a_idle: assert property (p_idle) else $error("idle drive");
	property p_oeOn; $rose(misoOe) |-> !csN; endproperty
	a_oeOn: assert property (p_oeOn) else $error("early drive");
	property p_soEdge; $changed(miso) && !csN |-> sclk; endproperty
	a_soEdge: assert property (p_soEdge) else $error("out edge");
	property p_csEdge; $changed(csN) |-> !sclk && !$past(sclk); endproperty
	a_csEdge: assert property (p_csEdge) else $error("select edge");
	property p_count; $rose(csN) |-> rise_r == 5'h10; endproperty
	a_count: assert property (p_count) else $error("pulse count");
	property p_inFrame; sclk |-> !csN && rise_r <= 5'h10; endproperty
	a_inFrame: assert property (p_inFrame) else $error("extra pulse");
	property p_siHold; $changed(mosi) |-> !sclk; endproperty
	a_siHold: assert property (p_siHold) else $error("data moved");
	property p_gap;
		$fell(csN) |-> high_r >= 10'(gds_pkg::CS_IDLE_CYC);
	endproperty
	a_gap: assert property (p_gap) else $error("short gap");
	c_frame: cover property ($fell(csN));
	c_commit: cover property ($rose(csN));
	c_drive: cover property ($rose(misoOe));
endmodule // gds_properties
`default_nettype wire

//--- bench/gauge_driver_spi_slave_tb_top.sv
// gauge_driver_spi_slave_tb_top: bench for both link ends
`timescale 1ns/100ps
`default_nettype none
module gauge_driver_spi_slave_tb_top;
	logic        clk, sysRst, psel, penable, pwrite, pready, pslverr;
	logic        wordCommitted, sclkQ;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [32:0] rd;
	logic [15:0] statusWord, shiftIn;
	logic [12:0] regV [6], expV [6];
	int          miscompares, checks, cyc, commits;
	gds_link_if link ();
	gds_controller gds_controller_i (.clk, .sys_rst(sysRst), .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.link(link.ctrl));
	gds_device gds_device_i (.clk, .sys_rst(sysRst), .link(link.dev),
		.statusWord, .wordCommitted, .powerEnableCalibration(regV[0]),
		.maximumVelocity(regV[1]), .gauge0TargetPosition(regV[2]),
		.gauge1TargetPosition(regV[3]), .returnToZeroCommand(regV[4]),
		.returnToZeroSetup(regV[5]));
	gds_properties gds_properties_i (.clk, .sys_rst(sysRst), .csN(link.csN),
		.sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
		.misoOe(link.misoOe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		sclkQ <= link.sclk;
		commits <= commits + int'(wordCommitted);
		if (!link.csN && sclkQ && !link.sclk)
			shiftIn <= {shiftIn[14:0], link.miso};
		if (cyc == 60000) begin
			miscompares++;
			give_verdict();
		end
	end
	task chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ok;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// settled values seen mid cycle are those the next edge samples
		do begin
			@(negedge clk);
			ok = pready;
			rd = {pslverr, prdata};
			@(posedge clk);
		end while (ok !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task send(input logic [15:0] w, s);
		statusWord <= s;
		apb(1'b1, gds_pkg::OFS_TXDATA, {16'h0000, w});
		apb(1'b1, gds_pkg::OFS_CTRL, 32'h00000001);
		do apb(1'b0, gds_pkg::OFS_STATUS, 32'h00000000);
		while (rd[gds_pkg::STAT_BUSY] !== 1'b0);
		chk("status", s, shiftIn);
	endtask
	// codes 6 and 7 go last so the commit count is known exactly
	task t_map;
		logic [12:0] v;
		for (int a = 0; a < 8; a++) begin
			v = 13'h1FFF - 13'(a);
			send({a[2:0], v}, 16'h8001 << a);
			if (a < 6)
				expV[a] = v;
			if (a == 5)
				chk("commits", 16'h0006, 16'(commits));
			foreach (regV[i])
				chk("reg", 16'(expV[i]), 16'(regV[i]));
		end
		$display("test map done");
	endtask
	task t_apb;
		apb(1'b0, 8'h10, 32'h00000000);
		chk("pslverr", 16'h0001, 16'(rd[32]));
		$display("test apb done");
	endtask
	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, sclkQ, sysRst} = 5'h01;
		{paddr, pwdata, statusWord, shiftIn, rd} = '0;
		{miscompares, checks, cyc, commits} = '0;
		expV = '{default: gds_pkg::REG_RESET};
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		t_map();
		t_apb();
		give_verdict();
	end
endmodule // gauge_driver_spi_slave_tb_top
`default_nettype wire
